// file: verification/count_source.sv
// External count source that toggles the count pin on request
`timescale 1ns/1ps

module count_source (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       start,
  input  wire logic [7:0] n_edges,
  output logic            count_pin,
  output logic            busy
);
  logic [7:0] left_r;
  logic [1:0] hold_r;

  assign busy = (left_r != 8'h00);

  // Each level lasts three clocks so no level can slip between samples
  always_ff @(posedge clock) begin
    if (reset) begin
      count_pin <= 1'b0;
      left_r    <= 8'h00;
      hold_r    <= 2'h0;
    end else if (!busy) begin
      left_r <= start ? n_edges : 8'h00;
      hold_r <= 2'h0;
    end else if (hold_r == 2'h2) begin
      count_pin <= !count_pin;
      left_r    <= left_r - 8'h01;
      hold_r    <= 2'h0;
    end else begin
      hold_r <= hold_r + 2'h1;
    end
  end
endmodule : count_source

// file: verification/tb_tick_counter_watchdog_prescaler.sv
// Self-checking bench for the tick counter, watchdog and prescalers
`timescale 1ns/1ps

module tb_tick_counter_watchdog_prescaler;
  import tick_wdog_pkg::*;
  logic       clock, reset, wr_stb, rd_stb, main_tick, sub_tick, pin, port_pin;
  logic       clr_ins, slp_ins, slp_mode, ext_irq, tick_ovf, wd_rst, start, busy;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, seed, got, n_edges;
  int         n_mismatch, checks_done, n, r, k, m, exp_cnt, lvl;

  tick_watchdog #(.STEP_CYCLES(2)) uut (
    .clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .main_clock_tick(main_tick), .sub_clock_tick(sub_tick),
    .count_pin(pin), .shared_port_pin(port_pin), .clear_watchdog_instruction(clr_ins),
    .sleep_instruction(slp_ins), .sleep_mode(slp_mode), .ext_irq(ext_irq),
    .tick_overflow(tick_ovf), .watchdog_reset(wd_rst));
  count_source src (.clock(clock), .reset(reset), .start(start), .n_edges(n_edges),
    .count_pin(pin), .busy(busy));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %0h seen %0h", nm, e, s);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [2:0] a, input logic [7:0] e, input string nm);
    @(posedge clock);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1 got = rdata;
    chk(nm, {24'h0, e}, {24'h0, got});
  endtask : rdchk

  // Pulses k core ticks back to back and counts overflow pulses meanwhile
  task automatic ticks(input int kk, input logic sub);
    r = 0;
    for (int i = 0; i < kk + 3; i++) begin
      @(posedge clock);
      if (tick_ovf === 1'b1) r++;
      main_tick <= (i < kk) && !sub;
      sub_tick  <= (i < kk) && sub;
    end
  endtask : ticks

  task automatic wd_time(input int lo, input int hi, input string nm);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wd_rst !== 1'b1 && n <= hi);
    chk(nm, lo, (n >= lo && n <= hi) ? lo : n);
  endtask : wd_time

  task automatic finish_test();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    {wr_stb, rd_stb, main_tick, sub_tick, port_pin, clr_ins, slp_ins, slp_mode} = 8'h00;
    {addr, wdata, start, n_edges} = 20'h00000;
    n_mismatch  = 0;
    checks_done = 0;
    seed        = 8'h49;
    reset       = 1'b1;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    for (int a = 0; a < 6; a++) rdchk(a[2:0], 8'h00, "reset_value");
    wr(3'h2, 8'hff);
    rdchk(3'h2, 8'hcf, "wdog_control");
    wr(3'h6, 8'hff);
    rdchk(3'h0, 8'h00, "unmapped_write");
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      wr(3'h2, {1'b0, seed[1], 6'h00});
      port_pin <= seed[0];
      repeat (2) @(posedge clock);
      #1 chk("ext_irq", {31'h0, seed[0] & seed[1]}, {31'h0, ext_irq});
      rdchk(3'h4, {7'h00, seed[0]}, "port_b");
    end
    seed = lfsr(seed);
    k = int'(seed[3:0]) + 1;
    m = int'(seed[7:4]);
    wr(3'h1, 8'(256 - k));
    ticks(k + m, 1'b0);
    chk("tick_overflow", 1, r);
    rdchk(3'h1, 8'(m), "tick_internal");
    wr(3'h3, 8'hff);
    rdchk(3'h3, 8'h40, "clock_select");
    wr(3'h1, 8'h00);
    ticks(3, 1'b0);
    ticks(4, 1'b1);
    rdchk(3'h1, 8'h04, "tick_sub_clock");
    wr(3'h3, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(3'h0, 8'h08 | 8'(c));
      wr(3'h1, 8'h00);
      ticks(3 * (2 << c) - 1, 1'b0);
      rdchk(3'h1, 8'h02, "tick_prescaled");
    end
    for (int e = 0; e < 2; e++) begin
      wr(3'h0, e ? 8'h30 : 8'h20);
      wr(3'h1, 8'h00);
      seed = lfsr(seed);
      n_edges <= {4'h0, seed[3:0]} | 8'h01;
      start   <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      lvl     = int'(pin);
      exp_cnt = 0;
      for (int i = 0; i < n_edges; i++) begin
        if (lvl == e) exp_cnt++;
        lvl = 1 - lvl;
      end
      n = 0;
      do begin
        @(posedge clock);
        n++;
      end while (busy !== 1'b0 && n < 200);
      repeat (4) @(posedge clock);
      rdchk(3'h1, 8'(exp_cnt), "tick_external");
    end
    wr(3'h0, 8'h00);
    wr(3'h2, 8'h87);
    wd_time(510, 516, "wdog_plain");
    wr(3'h2, 8'h00);
    wr(3'h2, 8'h80);
    repeat (300) @(posedge clock);
    clr_ins <= 1'b1;
    @(posedge clock);
    clr_ins <= 1'b0;
    wd_time(510, 516, "wdog_clear");
    wr(3'h2, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h80);
    repeat (300) @(posedge clock);
    slp_ins  <= 1'b1;
    slp_mode <= 1'b1;
    @(posedge clock);
    slp_ins <= 1'b0;
    ticks(5, 1'b0);
    wd_time(500, 508, "wdog_sleep");
    slp_mode <= 1'b0;
    rdchk(3'h1, 8'h00, "tick_asleep");
    for (int c = 0; c < 3; c++) begin
      wr(3'h2, 8'h00);
      wr(3'h2, 8'h88 | 8'(c));
      exp_cnt = 512 * (2 << c);
      wd_time(exp_cnt - 4, exp_cnt + 8, "wdog_prescaled");
    end
    wr(3'h2, 8'h07);
    r = 0;
    repeat (700) begin
      @(posedge clock);
      if (wd_rst === 1'b1) r++;
    end
    chk("wdog_disabled", 0, r);
    finish_test();
  end
endmodule : tb_tick_counter_watchdog_prescaler

// file: verilog/tick_watchdog.sv
// Tick counter, watchdog timer and their two prescalers behind a plain register port

`timescale 1ns/1ps

module tick_watchdog
  import tick_wdog_pkg::*;
#(
  parameter int STEP_CYCLES = WDOG_STEP_CYC
) (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  input  wire logic       main_clock_tick,
  input  wire logic       sub_clock_tick,
  input  wire logic       count_pin,
  input  wire logic       shared_port_pin,
  input  wire logic       clear_watchdog_instruction,
  input  wire logic       sleep_instruction,
  input  wire logic       sleep_mode,
  output logic            ext_irq,
  output logic            tick_overflow,
  output logic            watchdog_reset
);

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers

  // Low bits that must all be ones for a prescaler to pass a step
  function automatic logic [7:0] ratio_mask(input logic [2:0] code);
    ratio_mask = ~(8'hff << ({1'b0, code} + 4'h1));
  endfunction : ratio_mask

  ////////////////////////////////////////////////////////////////////////////
  // Register file and read port

  logic [7:0] control_r,  control_nxt;
  logic [7:0] wdog_ctl_r, wdog_ctl_nxt;
  logic [7:0] clk_sel_r,  clk_sel_nxt;
  logic [7:0] rdata_r,    rdata_nxt;
  logic       ext_irq_r,  ext_irq_nxt;
  logic [7:0] tick_cnt_r;

  logic wr_control;
  logic wr_tick;
  logic wr_wdog;
  logic wr_clksel;

  always_comb begin
    wr_control   = wr_stb && (addr == OFS_CONTROL);
    wr_tick      = wr_stb && (addr == OFS_TICK_COUNTER);
    wr_wdog      = wr_stb && (addr == OFS_WDOG_CONTROL);
    wr_clksel    = wr_stb && (addr == OFS_CLOCK_SELECT);
    control_nxt  = wr_control ? wdata : control_r;
    // Unused watchdog control and clock select bits are masked on the way in; control_r keeps every written bit
    wdog_ctl_nxt = wr_wdog ? (wdata & WDC_WRITABLE_MASK) : wdog_ctl_r;
    clk_sel_nxt  = wr_clksel ? (wdata & (8'h01 << CSEL_TICK_CLOCK)) : clk_sel_r;
    // Select low keeps the pin away from the interrupt logic
    ext_irq_nxt  = wdog_ctl_r[WDC_IRQ_SELECT] && shared_port_pin;
    rdata_nxt    = 8'h00;
    if (rd_stb) begin
      case (addr)
        OFS_CONTROL:      rdata_nxt = control_r;
        OFS_TICK_COUNTER: rdata_nxt = tick_cnt_r;
        OFS_WDOG_CONTROL: rdata_nxt = wdog_ctl_r;
        OFS_CLOCK_SELECT: rdata_nxt = clk_sel_r;
        OFS_PORT_B:       rdata_nxt = {7'h00, shared_port_pin};
        default:          rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      control_r  <= CONTROL_RESET;
      wdog_ctl_r <= WDOG_CONTROL_RESET;
      clk_sel_r  <= CLOCK_SELECT_RESET;
      rdata_r    <= 8'h00;
      ext_irq_r  <= 1'b0;
    end else begin
      control_r  <= control_nxt;
      wdog_ctl_r <= wdog_ctl_nxt;
      clk_sel_r  <= clk_sel_nxt;
      rdata_r    <= rdata_nxt;
      ext_irq_r  <= ext_irq_nxt;
    end
  end

  assign rdata   = rdata_r;
  assign ext_irq = ext_irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Tick counter and its prescaler

  logic [7:0] tick_cnt_nxt;
  logic [7:0] tick_pre_r, tick_pre_nxt;
  logic       pin_prev_r, pin_prev_nxt;
  logic       tick_ovf_r, tick_ovf_nxt;
  logic       core_tick;
  logic       pin_edge;
  logic       src_event;
  logic       tick_step;

  always_comb begin
    core_tick    = clk_sel_r[CSEL_TICK_CLOCK] ? sub_clock_tick : main_clock_tick;
    // Pin is synchronous, so one previous sample is enough for edge finding
    pin_edge     = control_r[CTL_TICK_EDGE] ? (pin_prev_r && !count_pin)
                                            : (!pin_prev_r && count_pin);
    src_event    = control_r[CTL_TICK_SOURCE] ? pin_edge : core_tick;
    tick_step    = 1'b0;
    tick_pre_nxt = tick_pre_r;
    tick_cnt_nxt = tick_cnt_r;
    tick_ovf_nxt = 1'b0;
    pin_prev_nxt = count_pin;
    if (!sleep_mode && src_event) begin
      tick_pre_nxt = tick_pre_r + 8'h01;
      if (control_r[CTL_PRESCALE_EN]) begin
        tick_step = (tick_pre_r & ratio_mask(control_r[2:0])) == ratio_mask(control_r[2:0]);
      end else begin
        tick_step = 1'b1;
      end
    end
    if (tick_step) begin
      tick_cnt_nxt = tick_cnt_r + 8'h01;
      tick_ovf_nxt = (tick_cnt_r == 8'hff);
    end
    // Software load wins over a count in the same cycle
    if (wr_tick) begin
      tick_cnt_nxt = wdata;
      tick_pre_nxt = 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      tick_cnt_r <= 8'h00;
      tick_pre_r <= 8'h00;
      pin_prev_r <= 1'b0;
      tick_ovf_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_pre_r <= tick_pre_nxt;
      pin_prev_r <= pin_prev_nxt;
      tick_ovf_r <= tick_ovf_nxt;
    end
  end

  assign tick_overflow = tick_ovf_r;

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: oscillator stand-in, prescaler, counter

  // The free-running oscillator is modelled by a divider off the block clock;
  // it ignores sleep so the watchdog keeps timing while the core is stopped.
  logic [31:0] osc_cnt_r, osc_cnt_nxt;
  logic [7:0]  wdog_pre_r, wdog_pre_nxt;
  logic [7:0]  wdog_cnt_r, wdog_cnt_nxt;
  logic        wdog_rst_r, wdog_rst_nxt;
  logic        osc_tick;
  logic        wdog_step;
  logic        wdog_clear;

  always_comb begin
    osc_tick     = (osc_cnt_r == 32'(STEP_CYCLES - 1));
    osc_cnt_nxt  = osc_tick ? 32'h0 : osc_cnt_r + 32'h1;
    wdog_pre_nxt = wdog_pre_r;
    wdog_cnt_nxt = wdog_cnt_r;
    wdog_rst_nxt = 1'b0;
    wdog_step    = 1'b0;
    if (osc_tick) begin
      wdog_pre_nxt = wdog_pre_r + 8'h01;
      if (wdog_ctl_r[WDC_PRESCALE_EN]) begin
        wdog_step = (wdog_pre_r & ratio_mask(wdog_ctl_r[2:0]))
                    == ratio_mask(wdog_ctl_r[2:0]);
      end else begin
        wdog_step = 1'b1;
      end
    end
    if (wdog_step) begin
      wdog_cnt_nxt = wdog_cnt_r + 8'h01;
      wdog_rst_nxt = (wdog_cnt_r == 8'hff) && wdog_ctl_r[WDC_ENABLE];
    end
    // A disabled watchdog is held cleared so enabling it starts a full period
    wdog_clear = clear_watchdog_instruction || sleep_instruction
                 || !wdog_ctl_r[WDC_ENABLE] || wdog_rst_r;
    if (wdog_clear) begin
      wdog_pre_nxt = 8'h00;
      wdog_cnt_nxt = 8'h00;
      osc_cnt_nxt  = 32'h0;
      wdog_rst_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      osc_cnt_r  <= 32'h0;
      wdog_pre_r <= 8'h00;
      wdog_cnt_r <= 8'h00;
      wdog_rst_r <= 1'b0;
    end else begin
      osc_cnt_r  <= osc_cnt_nxt;
      wdog_pre_r <= wdog_pre_nxt;
      wdog_cnt_r <= wdog_cnt_nxt;
      wdog_rst_r <= wdog_rst_nxt;
    end
  end

  assign watchdog_reset = wdog_rst_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_wdog_enable_write: assert property (
    @(posedge clock) disable iff (reset)
    wr_wdog |=> (wdog_ctl_r[WDC_ENABLE] == $past(wdata[WDC_ENABLE]))
                && (wdog_ctl_r[WDC_IRQ_SELECT] == $past(wdata[WDC_IRQ_SELECT])))
    else $error("watchdog control bits 7 and 6 did not take the written value");

  a_unused_bits_zero: assert property (
    @(posedge clock) disable iff (reset)
    wr_wdog |=> (wdog_ctl_r[5:4] == 2'b00) ##1 (wdog_ctl_r[5:4] == 2'b00))
    else $error("watchdog control unused bits became nonzero");

  a_irq_path_gate: assert property (
    @(posedge clock) disable iff (reset)
    !wdog_ctl_r[WDC_IRQ_SELECT] |=> !ext_irq_r)
    else $error("interrupt path open while pin select is low");

  a_port_read_level: assert property (
    @(posedge clock) disable iff (reset)
    (rd_stb && addr == OFS_PORT_B) |=> (rdata_r[0] == $past(shared_port_pin)))
    else $error("port read does not show the shared pin level");

  a_tick_write_clear: assert property (
    @(posedge clock) disable iff (reset)
    wr_tick |=> (tick_pre_r == 8'h00) && (tick_cnt_r == $past(wdata)))
    else $error("tick counter write did not load value and clear prescaler");

  a_wdog_instr_clear: assert property (
    @(posedge clock) disable iff (reset)
    (clear_watchdog_instruction || sleep_instruction)
      |=> (wdog_cnt_r == 8'h00) && (wdog_pre_r == 8'h00) && !wdog_rst_r)
    else $error("watchdog not cleared by clear or sleep instruction");

  a_tick_sleep_hold: assert property (
    @(posedge clock) disable iff (reset)
    (sleep_mode && !wr_tick) |=> $stable(tick_cnt_r) && $stable(tick_pre_r))
    else $error("tick counter moved during sleep");

  a_tick_plain_step: assert property (
    @(posedge clock) disable iff (reset)
    (!control_r[CTL_TICK_SOURCE] && !control_r[CTL_PRESCALE_EN] && !sleep_mode
      && !wr_tick && core_tick) |=> (tick_cnt_r == $past(tick_cnt_r) + 8'h01))
    else $error("tick counter did not step on the internal clock");

  a_edge_step: assert property (
    @(posedge clock) disable iff (reset)
    (control_r[CTL_TICK_SOURCE] && !control_r[CTL_PRESCALE_EN] && !sleep_mode
      && !wr_tick && !pin_edge) |=> (tick_cnt_r == $past(tick_cnt_r)))
    else $error("tick counter moved without a count pin edge");

  a_timeout_enabled: assert property (
    @(posedge clock) disable iff (reset)
    $rose(wdog_rst_r) |-> $past(wdog_ctl_r[WDC_ENABLE]) && ($past(wdog_cnt_r) == 8'hff)
                          ##1 (wdog_cnt_r == 8'h00))
    else $error("watchdog reset without an enabled full count");

  a_reset_clears: assert property (
    @(posedge clock)
    reset |=> (wdog_cnt_r == 8'h00) && (wdog_pre_r == 8'h00) && !wdog_rst_r)
    else $error("reset did not clear the watchdog");

  a_disabled_quiet: assert property (
    @(posedge clock) disable iff (reset)
    !wdog_ctl_r[WDC_ENABLE] |=> !wdog_rst_r && (wdog_cnt_r == 8'h00))
    else $error("disabled watchdog is counting or firing");

endmodule : tick_watchdog

// file: verilog/tick_wdog_pkg.sv
// Constants shared by the tick counter, watchdog and prescaler block
package tick_wdog_pkg;

  // Register indices on the plain register port
  localparam logic [2:0] OFS_CONTROL      = 3'h0;
  localparam logic [2:0] OFS_TICK_COUNTER = 3'h1;
  localparam logic [2:0] OFS_WDOG_CONTROL = 3'h2;
  localparam logic [2:0] OFS_CLOCK_SELECT = 3'h3;
  localparam logic [2:0] OFS_PORT_B       = 3'h4;

  // control_register fields
  localparam int CTL_TICK_SOURCE  = 5;
  localparam int CTL_TICK_EDGE    = 4;
  localparam int CTL_PRESCALE_EN  = 3;
  localparam int CTL_RATIO_LSB    = 0;

  // watchdog_control fields
  localparam int WDC_ENABLE       = 7;
  localparam int WDC_IRQ_SELECT   = 6;
  localparam int WDC_PRESCALE_EN  = 3;
  localparam int WDC_RATIO_LSB    = 0;
  localparam logic [7:0] WDC_WRITABLE_MASK = 8'hcf;

  // bank0_clock_select_register field
  localparam int CSEL_TICK_CLOCK  = 6;

  // Reset values
  localparam logic [7:0] CONTROL_RESET      = 8'h00;
  localparam logic [7:0] WDOG_CONTROL_RESET = 8'h00;
  localparam logic [7:0] CLOCK_SELECT_RESET = 8'h00;

  // Timing: unprescaled watchdog period and the clock rate
  localparam longint WDOG_PERIOD_NS    = 16500000;
  localparam longint CLOCK_PERIOD_NS   = 25;
  localparam longint WDOG_PERIOD_CYC   = WDOG_PERIOD_NS / CLOCK_PERIOD_NS;
  // One watchdog counter step; 256 steps make one unprescaled period
  localparam longint WDOG_STEPS        = 256;
  localparam longint WDOG_STEP_CYC_RAW = WDOG_PERIOD_CYC / WDOG_STEPS;
  localparam int     WDOG_STEP_CYC     = (WDOG_STEP_CYC_RAW < 1) ? 1 : int'(WDOG_STEP_CYC_RAW);

endpackage : tick_wdog_pkg
